/* rtl/gtic_pkg.sv */
// Purpose: Shared constants for the pin and tick interrupt control block.
// Assumes: APB slave with 32-bit data, registers in the low byte of a word.
package gtic_pkg;
    localparam logic [31:0] IDX_INPUT_CTRL = 32'hfff42018;
    localparam logic [31:0] IDX_PIN_CTRL   = 32'hfff42019;
    localparam logic [31:0] IDX_T2_CTRL    = 32'hfff4201a;
    localparam logic [31:0] IDX_T1_CTRL    = 32'hfff4201b;
    localparam int          ADDR_W         = 12;
    localparam int          B_POL          = 7;
    localparam int          B_EDGE         = 6;
    localparam int          B_PEND         = 5;
    localparam int          B_EN           = 4;
    localparam int          B_CLR          = 3;
    localparam int          LVL_W          = 3;
    localparam int          B_GPI          = 2;
    localparam int          B_OE           = 1;
    localparam int          B_OUT          = 0;
    localparam logic [7:0]  RST_CTRL       = 8'h00;
    localparam int          NSRC           = 3;
    localparam int          SRC_GPIO       = 0;
    localparam int          SRC_T1         = 1;
    localparam int          SRC_T2         = 2;

    typedef enum logic {APB_IDLE, APB_ACK} gtic_apb_t;

    // Word index of the APB address matched against the low bits of an index.
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [31:0] idx);
        return a[ADDR_W-1:2] == idx[ADDR_W-3:0];
    endfunction

    function automatic logic [31:0] srcIdx(input int s);
        return (s == SRC_GPIO) ? IDX_INPUT_CTRL : (s == SRC_T1) ? IDX_T1_CTRL : IDX_T2_CTRL;
    endfunction
endpackage

/* rtl/gtic_src_if.sv */
// Purpose: Control and status of one interrupt source.
// Assumes: One clock domain.
// Notes: The controller drives mode and strobes, the source returns status.
`timescale 1ns/1ns
interface gtic_src_if;
    logic       edgeMode;
    logic       evt;
    logic       lvlIn;
    logic       clr;
    logic       en;
    logic [2:0] lvl;
    logic       pend;
    logic [2:0] req;
    modport src (input edgeMode, evt, lvlIn, clr, en, lvl, output pend, req);
    modport ctl (output edgeMode, evt, lvlIn, clr, en, lvl, input pend, req);
endinterface

/* rtl/gtic_pin_sync.sv */
// Purpose: Synchronise the pin and flag its edges.
// Assumes: Pin is asynchronous to clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ns
module gtic_pin_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pinIn,
    output logic      pinLvl,
    output logic      pinRise,
    output logic      pinFall
);
    logic metaQ;
    logic syncQ;
    logic prevQ;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            metaQ <= 1'b0;
            syncQ <= 1'b0;
            prevQ <= 1'b0;
        end
        else
        begin
            metaQ <= pinIn;
            syncQ <= metaQ;
            prevQ <= syncQ;
        end
    end

    assign pinLvl  = syncQ;
    assign pinRise = syncQ & ~prevQ;
    assign pinFall = ~syncQ & prevQ;

    property p_one_edge;
        @(posedge clk) disable iff (!rst_n) (pinRise || pinFall) |=> !(pinRise || pinFall);
    endproperty
    a_one_edge: assert property (p_one_edge) else $error("Pin edge flagged twice.");
endmodule

/* rtl/gtic_src.sv */
// Purpose: Pending capture and gated request for one interrupt source.
// Assumes: Event is a one-cycle pulse.
// Notes: Request is registered, one cycle behind pending.
`timescale 1ns/1ns
module gtic_src (
    input wire logic clk,
    input wire logic rst_n,
    gtic_src_if.src  s
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s.pend <= 1'b0;
        else if (!s.edgeMode)
            s.pend <= s.lvlIn;
        else if (s.evt)
            s.pend <= 1'b1;
        else if (s.clr)
            s.pend <= 1'b0;
    end

    // A level of zero is treated like a disabled source.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s.req <= 3'h0;
        else if (s.pend && s.en && s.lvl != 3'h0)
            s.req <= s.lvl;
        else
            s.req <= 3'h0;
    end

    property p_req_gate;
        (s.pend && s.en && s.lvl != 3'h0) |=> s.req == $past(s.lvl);
    endproperty
    a_req_gate: assert property (p_req_gate) else $error("Request level wrong.");

    property p_req_zero;
        (!s.en || s.lvl == 3'h0) |=> s.req == 3'h0;
    endproperty
    a_req_zero: assert property (p_req_zero) else $error("Request not blocked.");

    property p_req_pend;
        (s.req != 3'h0) |-> $past(s.pend);
    endproperty
    a_req_pend: assert property (p_req_pend) else $error("Request without pending.");

    property p_set_wins;
        (s.edgeMode && s.evt) |=> s.pend;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("Event lost.");

    property p_clr;
        (s.edgeMode && s.clr && !s.evt) |=> !s.pend;
    endproperty
    a_clr: assert property (p_clr) else $error("Clear ignored.");

    property p_level;
        !s.edgeMode |=> s.pend == $past(s.lvlIn);
    endproperty
    a_level: assert property (p_level) else $error("Level pending wrong.");
endmodule

/* rtl/gtic_top.sv */
// Purpose: APB registers for pin control, input pin and tick timer interrupts.
// Assumes: Timer counts and compares come from the tick timer block.
// Notes: One wait state on every APB access.
`timescale 1ns/1ns
module gtic_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        gpioPinIn,
    output logic             gpioPinOut,
    output logic             gpioPinOeN,
    input  wire logic [31:0] tick1Count,
    input  wire logic [31:0] tick1Compare,
    input  wire logic [31:0] tick2Count,
    input  wire logic [31:0] tick2Compare,
    output logic      [2:0]  gpioIrqLevel,
    output logic      [2:0]  tick1IrqLevel,
    output logic      [2:0]  tick2IrqLevel
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    gtic_pkg::gtic_apb_t apbStateQ;
    logic [31:0] prdataQ;
    logic        preadyQ;
    logic        pslverrQ;
    logic        polQ;
    logic        edgeQ;
    logic        edgeD;
    logic        pinOutQ;
    logic        pinOeNQ;
    logic [1:0]  matchQ;
    logic [1:0]  matchD;
    logic [gtic_pkg::NSRC-1:0] enQ;
    logic [2:0]  lvlQ [gtic_pkg::NSRC];
    logic [gtic_pkg::NSRC-1:0] srcHit;
    logic [gtic_pkg::NSRC-1:0] srcClr;
    logic [gtic_pkg::NSRC-1:0] srcEvt;
    logic [gtic_pkg::NSRC-1:0] srcEdge;
    logic [gtic_pkg::NSRC-1:0] srcPend;
    logic        pinHit;
    logic        wrEn;
    logic        mapped;
    logic [7:0]  rdByte;
    logic        pinLvl;
    logic        pinRise;
    logic        pinFall;

    gtic_src_if srcIf [gtic_pkg::NSRC] ();

    gtic_pin_sync u_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .pinIn   (gpioPinIn),
        .pinLvl  (pinLvl),
        .pinRise (pinRise),
        .pinFall (pinFall)
    );

    // Writes land at the edge where the master sees pready high.
    assign wrEn   = psel && penable && pwrite && preadyQ;
    assign pinHit = gtic_pkg::hit(paddr, gtic_pkg::IDX_PIN_CTRL);
    assign mapped = pinHit || (|srcHit);

    // The new edge select governs the same write, so a clear sent with it works.
    assign edgeD = (wrEn && srcHit[gtic_pkg::SRC_GPIO]) ? pwdata[gtic_pkg::B_EDGE] : edgeQ;

    assign matchD[0] = tick1Count == tick1Compare;
    assign matchD[1] = tick2Count == tick2Compare;

    always_comb
    begin
        srcEdge = '1;
        srcEvt  = '0;
        srcEdge[gtic_pkg::SRC_GPIO] = edgeD;
        srcEvt[gtic_pkg::SRC_GPIO]  = polQ ? pinFall : pinRise;
        srcEvt[gtic_pkg::SRC_T1]    = matchD[0] & ~matchQ[0];
        srcEvt[gtic_pkg::SRC_T2]    = matchD[1] & ~matchQ[1];
    end

    genvar gi;
    generate
        for (gi = 0; gi < gtic_pkg::NSRC; gi++)
        begin : g_src
            assign srcHit[gi] = gtic_pkg::hit(paddr, gtic_pkg::srcIdx(gi));
            assign srcClr[gi] = wrEn && srcHit[gi] && pwdata[gtic_pkg::B_CLR];
            assign srcIf[gi].edgeMode = srcEdge[gi];
            assign srcIf[gi].evt      = srcEvt[gi];
            assign srcIf[gi].lvlIn    = (gi == gtic_pkg::SRC_GPIO) ? (pinLvl ^ polQ) : 1'b0;
            assign srcIf[gi].clr      = srcClr[gi];
            assign srcIf[gi].en       = enQ[gi];
            assign srcIf[gi].lvl      = lvlQ[gi];
            // Pending is copied out here because an interface array takes only constant indices.
            assign srcPend[gi]        = srcIf[gi].pend;
            gtic_src u_src (
                .clk   (clk),
                .rst_n (rst_n),
                .s     (srcIf[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            matchQ <= 2'h0;
        else
            matchQ <= matchD;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            enQ <= '0;
            for (int i = 0; i < gtic_pkg::NSRC; i++)
                lvlQ[i] <= gtic_pkg::RST_CTRL[2:0];
        end
        else
        begin
            for (int i = 0; i < gtic_pkg::NSRC; i++)
            begin
                if (wrEn && srcHit[i])
                begin
                    enQ[i]  <= pwdata[gtic_pkg::B_EN];
                    lvlQ[i] <= pwdata[gtic_pkg::LVL_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            polQ  <= 1'b0;
            edgeQ <= 1'b0;
        end
        else
        begin
            edgeQ <= edgeD;
            if (wrEn && srcHit[gtic_pkg::SRC_GPIO])
                polQ <= pwdata[gtic_pkg::B_POL];
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinOutQ <= 1'b0;
            pinOeNQ <= 1'b1;
        end
        else if (wrEn && pinHit)
        begin
            pinOutQ <= pwdata[gtic_pkg::B_OUT];
            pinOeNQ <= ~pwdata[gtic_pkg::B_OE];
        end
    end

    // Clear strobes are never stored, so they read back as zero.
    always_comb
    begin
        rdByte = 8'h00;
        if (srcHit[gtic_pkg::SRC_GPIO])
        begin
            rdByte[gtic_pkg::B_POL]  = polQ;
            rdByte[gtic_pkg::B_EDGE] = edgeQ;
        end
        for (int i = 0; i < gtic_pkg::NSRC; i++)
        begin
            if (srcHit[i])
            begin
                rdByte[gtic_pkg::B_PEND]        = srcPend[i];
                rdByte[gtic_pkg::B_EN]          = enQ[i];
                rdByte[gtic_pkg::LVL_W-1:0]     = lvlQ[i];
                rdByte[gtic_pkg::B_CLR]         = 1'b0;
            end
        end
        if (pinHit)
        begin
            rdByte[gtic_pkg::B_GPI] = pinLvl;
            rdByte[gtic_pkg::B_OE]  = ~pinOeNQ;
            rdByte[gtic_pkg::B_OUT] = pinOutQ;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            apbStateQ <= gtic_pkg::APB_IDLE;
            preadyQ   <= 1'b0;
            pslverrQ  <= 1'b0;
            prdataQ   <= 32'h0;
        end
        else
        begin
            unique case (apbStateQ)
                gtic_pkg::APB_IDLE:
                begin
                    if (psel && penable)
                    begin
                        apbStateQ <= gtic_pkg::APB_ACK;
                        preadyQ   <= 1'b1;
                        pslverrQ  <= ~mapped;
                        prdataQ   <= pwrite ? 32'h0 : {24'h0, rdByte};
                    end
                end
                gtic_pkg::APB_ACK:
                begin
                    apbStateQ <= gtic_pkg::APB_IDLE;
                    preadyQ   <= 1'b0;
                    pslverrQ  <= 1'b0;
                end
            endcase
        end
    end

    assign prdata        = prdataQ;
    assign pready        = preadyQ;
    assign pslverr       = pslverrQ;
    assign gpioPinOut    = pinOutQ;
    assign gpioPinOeN    = pinOeNQ;
    assign gpioIrqLevel  = srcIf[gtic_pkg::SRC_GPIO].req;
    assign tick1IrqLevel = srcIf[gtic_pkg::SRC_T1].req;
    assign tick2IrqLevel = srcIf[gtic_pkg::SRC_T2].req;

    sequence s_access;
        psel && penable && !preadyQ;
    endsequence

    sequence s_done;
        preadyQ ##1 !preadyQ;
    endsequence

    property p_answer;
        s_access |=> s_done;
    endproperty
    a_answer: assert property (p_answer) else $error("APB answer late.");

    property p_clr_zero;
        (preadyQ && !pwrite) |-> prdataQ[gtic_pkg::B_CLR] == 1'b0;
    endproperty
    a_clr_zero: assert property (p_clr_zero) else $error("Clear bit read as one.");

    property p_drive;
        (wrEn && pinHit) |=> gpioPinOeN == !$past(pwdata[gtic_pkg::B_OE])
            && gpioPinOut == $past(pwdata[gtic_pkg::B_OUT]);
    endproperty
    a_drive: assert property (p_drive) else $error("Pin drive wrong.");

    property p_tick1;
        (matchD[0] && !matchQ[0]) |=> srcIf[gtic_pkg::SRC_T1].pend ##1
            (tick1IrqLevel == 3'h0 || tick1IrqLevel == lvlQ[gtic_pkg::SRC_T1]);
    endproperty
    a_tick1: assert property (p_tick1) else $error("Timer one event lost.");

    property p_t2_zero;
        (lvlQ[gtic_pkg::SRC_T2] == 3'h0) [*2] |-> tick2IrqLevel == 3'h0;
    endproperty
    a_t2_zero: assert property (p_t2_zero) else $error("Timer two level zero.");

    property p_gpio_edge;
        (edgeQ && edgeD && !polQ && pinRise) |=> srcIf[gtic_pkg::SRC_GPIO].pend;
    endproperty
    a_gpio_edge: assert property (p_gpio_edge) else $error("Rising edge lost.");

    property p_gpio_lvl;
        (!edgeD && polQ) |=> srcIf[gtic_pkg::SRC_GPIO].pend == !$past(pinLvl);
    endproperty
    a_gpio_lvl: assert property (p_gpio_lvl) else $error("Low level not seen.");
endmodule

/* tb/gtic_far_model.sv */
// Purpose: Far side of the block: outside pin level and two free running tick counters.
// Assumes: Counters step every clock, which only shortens the wait for a compare.
// Notes: The pin wire is resolved from the block's drive and the outside level.
`timescale 1ns/1ns
module gtic_far_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        extPin,
    input  wire logic        gpioPinOut,
    input  wire logic        gpioPinOeN,
    output logic             pinWire,
    output logic      [31:0] tick1Count,
    output logic      [31:0] tick2Count
);
    // The block wins over the outside level while it drives, as a strong driver would.
    assign pinWire = (gpioPinOeN === 1'b0) ? gpioPinOut : extPin;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick1Count <= 32'h0;
            tick2Count <= 32'h100;
        end
        else
        begin
            tick1Count <= tick1Count + 32'h1;
            tick2Count <= tick2Count + 32'h1;
        end
    end
endmodule

/* tb/gpio_and_tick_irq_control_tb.sv */
// Purpose: Self-checking bench for the pin and tick interrupt control block.
// Assumes: APB answers come with pready; reads are compared by a watching process.
// Notes: Expected read data is queued by the driver and popped at each answer.
`timescale 1ns/1ns
module gpio_and_tick_irq_control_tb;
    typedef struct packed {logic rd; logic [31:0] d; logic e;} gtic_exp_t;
    localparam logic [11:0] AIN  = 12'(gtic_pkg::IDX_INPUT_CTRL << 2);
    localparam logic [11:0] APIN = 12'(gtic_pkg::IDX_PIN_CTRL << 2);
    localparam logic [11:0] AT2  = 12'(gtic_pkg::IDX_T2_CTRL << 2);
    localparam logic [11:0] AT1  = 12'(gtic_pkg::IDX_T1_CTRL << 2);
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, extPin, pinWire;
    logic        gpioPinOut, gpioPinOeN;
    logic [11:0] paddr, a;
    logic [31:0] pwdata, prdata, tick1Count, tick2Count, tick1Compare, tick2Compare;
    logic [2:0]  gpioIrqLevel, tick1IrqLevel, tick2IrqLevel, lv;
    int          err_total, cmp_count;
    gtic_exp_t   expQ[$];
    gtic_exp_t   ex;

    gtic_top dut_u (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gpioPinIn(pinWire), .gpioPinOut(gpioPinOut), .gpioPinOeN(gpioPinOeN),
        .tick1Count(tick1Count), .tick1Compare(tick1Compare), .tick2Count(tick2Count),
        .tick2Compare(tick2Compare), .gpioIrqLevel(gpioIrqLevel),
        .tick1IrqLevel(tick1IrqLevel), .tick2IrqLevel(tick2IrqLevel));

    gtic_far_model far_u (.clk(clk), .rst_n(rst_n), .extPin(extPin), .gpioPinOut(gpioPinOut),
        .gpioPinOeN(gpioPinOeN), .pinWire(pinWire), .tick1Count(tick1Count),
        .tick2Count(tick2Count));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // One APB transfer; the request is held until pready is seen at a rising edge.
    task automatic apb(input logic [11:0] ad, input logic w, input logic [7:0] d,
                       input logic [31:0] ed, input logic ee);
        int n;
        n = 0;
        expQ.push_back('{!w, ed, ee});
        @(posedge clk);
        paddr <= ad;
        pwrite <= w;
        pwdata <= {24'h000000, d};
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            err_total++;
            stop_test();
        end
    endtask

    task automatic wr(input logic [11:0] ad, input logic [7:0] d);
        apb(ad, 1'b1, d, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [11:0] ad, input logic [31:0] ed);
        apb(ad, 1'b0, 8'h00, ed, 1'b0);
    endtask

    // Sets a compare a few counts ahead so the equality happens once, then lets it land.
    task automatic fire(input int s);
        if (s == 1)
            tick2Compare <= tick2Count + 32'd6;
        else
            tick1Compare <= tick1Count + 32'd6;
        idle(12);
    endtask

    always @(posedge clk)
        if (rst_n === 1'b1 && pready === 1'b1)
        begin
            if (expQ.size() == 0)
                chk(32'h1, 32'h0, "unexpected answer");
            else
            begin
                ex = expQ.pop_front();
                chk({31'h0, pslverr}, {31'h0, ex.e}, "pslverr");
                if (ex.rd)
                    chk(prdata, ex.d, "prdata");
            end
        end

    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        extPin = 1'b0;
        tick1Compare = 32'hffffffff;
        tick2Compare = 32'hffffffff;
        err_total = 0;
        cmp_count = 0;
        void'($urandom(32));
        idle(8);
        rst_n <= 1'b1;
        rd(AIN, 32'h0);
        rd(APIN, 32'h0);
        rd(AT2, 32'h0);
        rd(AT1, 32'h0);
        chk({31'h0, gpioPinOeN}, 32'h1, "pin drive off");
        apb(12'h0f0, 1'b0, 8'h00, 32'h0, 1'b1);
        apb(12'h0f0, 1'b1, 8'hff, 32'h0, 1'b1);
        for (int s = 0; s < 2; s++)
        begin
            lv = 3'($urandom_range(7, 1));
            a = (s == 1) ? AT2 : AT1;
            wr(a, {5'h02, lv});
            fire(s);
            chk(32'((s == 1) ? tick2IrqLevel : tick1IrqLevel), 32'(lv), "tick irq");
            chk(32'((s == 1) ? tick1IrqLevel : tick2IrqLevel), 32'h0, "idle irq");
            rd(a, {24'h0, 5'h06, lv});
            wr(a, {5'h03, lv});
            rd(a, {24'h0, 5'h02, lv});
            chk(32'((s == 1) ? tick2IrqLevel : tick1IrqLevel), 32'h0, "cleared irq");
            wr(a, 8'h18);
            fire(s);
            chk(32'((s == 1) ? tick2IrqLevel : tick1IrqLevel), 32'h0, "level zero");
            wr(a, {5'h01, lv});
            fire(s);
            chk(32'((s == 1) ? tick2IrqLevel : tick1IrqLevel), 32'h0, "disabled");
            rd(a, {24'h0, 5'h04, lv});
            wr(a, 8'h08);
        end
        // Each change of edge select carries the clear strobe, as software should.
        wr(AIN, 8'h5b);
        extPin <= 1'b1;
        idle(8);
        chk(32'(gpioIrqLevel), 32'h3, "rise irq");
        rd(AIN, 32'h73);
        extPin <= 1'b0;
        idle(8);
        rd(AIN, 32'h73);
        wr(AIN, 8'h5b);
        rd(AIN, 32'h53);
        wr(AIN, 8'hdb);
        extPin <= 1'b1;
        idle(8);
        rd(AIN, 32'hd3);
        extPin <= 1'b0;
        idle(8);
        rd(AIN, 32'hf3);
        wr(AIN, 8'h9b);
        idle(4);
        rd(AIN, 32'hb3);
        wr(AIN, 8'h9b);
        rd(AIN, 32'hb3);
        extPin <= 1'b1;
        idle(8);
        rd(AIN, 32'h93);
        chk(32'(gpioIrqLevel), 32'h0, "low level off");
        wr(AIN, 8'h15);
        idle(4);
        chk(32'(gpioIrqLevel), 32'h5, "high level");
        wr(AIN, 8'h05);
        idle(4);
        chk(32'(gpioIrqLevel), 32'h0, "gate off");
        rd(AIN, 32'h25);
        wr(AIN, 8'h10);
        idle(4);
        chk(32'(gpioIrqLevel), 32'h0, "level zero");
        wr(APIN, 8'h02);
        extPin <= 1'b1;
        idle(6);
        chk({30'h0, gpioPinOeN, gpioPinOut}, 32'h0, "drive low");
        rd(APIN, 32'h02);
        wr(APIN, 8'h03);
        idle(6);
        rd(APIN, 32'h07);
        wr(APIN, 8'h00);
        extPin <= 1'b0;
        idle(6);
        chk({30'h0, gpioPinOeN, gpioPinOut}, 32'h2, "released");
        rd(APIN, 32'h00);
        idle(4);
        stop_test();
    end
endmodule
